// ==== core/ump_pin_ctrl.sv ====
/*
  Pin control of one serial channel: modem pins, infrared polarity,
  general output two with interrupt gating, and a register port.
  Assumes pins are asynchronous and synchronised here; the register
  master issues one-cycle strobes and reads data in the next cycle.
*/
`timescale 1ns/10ps
module ump_pin_ctrl
  import ump_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial pins
  input  wire logic       serial_receive_in,
  output logic            serial_transmit_out,
  output logic            request_to_send_out_n,
  input  wire logic       clear_to_send_in_n,
  output logic            terminal_ready_out_n,
  input  wire logic       set_ready_in_n,
  input  wire logic       carrier_detect_in_n,
  input  wire logic       ring_indicator_in_n,
  output logic            general_output_two_n,
  // Interrupt pin
  input  wire logic       irq_request,
  output logic            interrupt_out,
  output logic            interrupt_oe,
  // Decoder side
  output logic            decoder_in
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] modem_control_register;
  logic [7:0] feature_control_register;
  logic [7:0] enhanced_feature_register;
  logic [7:0] next_mcr;
  logic [7:0] next_feature_control_register;
  logic [7:0] next_efr;
  logic [7:0] next_rdata;
  logic       tx_go;
  logic [7:0] tx_data;
  logic       next_go;
  logic [7:0] next_txd;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rx_s;
  logic cts_s;
  logic dsr_s;
  logic cd_s;
  logic ri_s;

  ump_sync #(.RST_VAL(1'b1)) u_rx (
    .clk   (clk),
    .reset (reset),
    .pin   (serial_receive_in),
    .sync  (rx_s)
  );
  ump_sync #(.RST_VAL(1'b1)) u_cts (
    .clk   (clk),
    .reset (reset),
    .pin   (clear_to_send_in_n),
    .sync  (cts_s)
  );
  ump_sync #(.RST_VAL(1'b1)) u_dsr (
    .clk   (clk),
    .reset (reset),
    .pin   (set_ready_in_n),
    .sync  (dsr_s)
  );
  ump_sync #(.RST_VAL(1'b1)) u_cd (
    .clk   (clk),
    .reset (reset),
    .pin   (carrier_detect_in_n),
    .sync  (cd_s)
  );
  ump_sync #(.RST_VAL(1'b1)) u_ri (
    .clk   (clk),
    .reset (reset),
    .pin   (ring_indicator_in_n),
    .sync  (ri_s)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic ir_mode;
  logic ir_invert;
  logic auto_cts;
  logic auto_dir;
  logic op2_bit;

  assign ir_mode   = modem_control_register[UMP_MCR_IR];
  assign ir_invert = feature_control_register[UMP_FEATURE_CONTROL_REGISTER_IRIN];
  assign auto_cts  = enhanced_feature_register[UMP_EFR_ACTS];
  assign auto_dir  = feature_control_register[UMP_FEATURE_CONTROL_REGISTER_DIR];
  assign op2_bit   = modem_control_register[UMP_MCR_OP2];

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  // Infrared idles low; the option flips a high-idle transceiver
  logic rx_line;
  logic next_dec;

  // Standard mode relies on the far end idling the line high
  assign rx_line = ir_mode ? (rx_s ^ ir_invert) : rx_s;

  always_comb begin
    // Receive is ignored during reset: decoder sees the idle level
    next_dec = rx_line;
    if (reset) begin
      next_dec = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    decoder_in <= next_dec;
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic tx_busy;
  logic tx_line;
  logic cts_block;
  logic next_tx_out;

  // Only clear-to-send may stall; the status inputs are never read here
  assign cts_block = auto_cts & cts_s;

  ump_tx_shift u_tx (
    .clk       (clk),
    .reset     (reset),
    .go        (tx_go),
    .data      (tx_data),
    .cts_block (cts_block),
    .busy      (tx_busy),
    .line      (tx_line)
  );

  always_comb begin
    // Infrared output is pulse-style: idle low, a zero bit gives a pulse
    next_tx_out = ir_mode ? ~tx_line : tx_line;
    if (reset) begin
      next_tx_out = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    serial_transmit_out <= next_tx_out;
  end

  // ----------------------------------------------------------------
  // Modem outputs
  // ----------------------------------------------------------------
  logic next_rts_n;
  logic next_dtr_n;
  logic next_op2_n;
  logic next_int;
  logic next_int_oe;

  // Software-set level unless auto direction overrides it with the busy flag; auto flow leaves it alone
  always_comb begin
    next_rts_n = ~modem_control_register[UMP_MCR_RTS];
    if (auto_dir) begin
      next_rts_n = ~tx_busy;
    end
    next_dtr_n  = ~modem_control_register[UMP_MCR_DTR];
    next_op2_n  = ~op2_bit;
    next_int    = irq_request & op2_bit;
    next_int_oe = op2_bit;
    if (reset) begin
      next_rts_n  = 1'b1;
      next_dtr_n  = 1'b1;
      next_op2_n  = 1'b1;
      next_int    = 1'b0;
      next_int_oe = 1'b0;
    end
  end

  // Interrupt and output two share one bit, so neither is free
  always_ff @(posedge clk) begin
    request_to_send_out_n <= next_rts_n;
    terminal_ready_out_n  <= next_dtr_n;
    general_output_two_n  <= next_op2_n;
    interrupt_out         <= next_int;
    interrupt_oe          <= next_int_oe;
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    next_mcr   = modem_control_register;
    next_feature_control_register  = feature_control_register;
    next_efr   = enhanced_feature_register;
    next_go    = 1'b0;
    next_txd   = tx_data;
    next_rdata = UMP_ZERO;
    if (reg_wr) begin
      if (reg_addr == UMP_ADDR_MCR) begin
        next_mcr = reg_wdata;
      end else if (reg_addr == UMP_ADDR_FEATURE_CONTROL_REGISTER) begin
        next_feature_control_register = reg_wdata;
      end else if (reg_addr == UMP_ADDR_EFR) begin
        next_efr = reg_wdata;
      end else if (reg_addr == UMP_ADDR_TXD) begin
        // A write while busy is dropped; software polls the status word
        next_go  = ~tx_busy;
        next_txd = tx_busy ? tx_data : reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == UMP_ADDR_MCR) begin
        next_rdata = modem_control_register;
      end else if (reg_addr == UMP_ADDR_FEATURE_CONTROL_REGISTER) begin
        next_rdata = feature_control_register;
      end else if (reg_addr == UMP_ADDR_EFR) begin
        next_rdata = enhanced_feature_register;
      end else if (reg_addr == UMP_ADDR_MSR) begin
        // Asserted-low pins reported as ones
        next_rdata = {~cd_s, ~ri_s, ~dsr_s, ~cts_s, 4'h0};
      end else if (reg_addr == UMP_ADDR_STAT) begin
        next_rdata = {7'h00, tx_busy};
      end
    end
    if (reset) begin
      next_mcr   = UMP_MCR_RST;
      next_feature_control_register  = UMP_FEATURE_CONTROL_REGISTER_RST;
      next_efr   = UMP_EFR_RST;
      next_go    = 1'b0;
      next_txd   = UMP_ZERO;
      next_rdata = UMP_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    modem_control_register    <= next_mcr;
    feature_control_register  <= next_feature_control_register;
    enhanced_feature_register <= next_efr;
    tx_go                     <= next_go;
    tx_data                   <= next_txd;
    reg_rdata                 <= next_rdata;
  end

endmodule : ump_pin_ctrl

// ==== inc/ump_pkg.sv ====
/*
  Constants, register map and enumerations of the channel pin-control block.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
// Operation
// - Infrared receive input is expected to idle low between pulses.
// - A feature-control bit inverts infrared receive before the decoder.
// - Output-port-2 bit set: general output low, interrupt pin driven.
// - Output-port-2 bit clear: general output high, interrupt pin floats.
// - Set-ready, carrier and ring inputs are status only, no serial effect.
// - Clear-to-send gates transmit when auto flow enabled, else status.
// - Long reset pulse returns registers and outputs to default.
// - During reset transmit stays high and receive input is ignored.
// - Infrared bit selects infrared interface, transmit idles low; else high.
// - Auto direction: request-to-send high receiving, low transmitting.
package ump_pkg;

  // ----------------------------------------------------------------
  // Register map (word index equals address)
  // ----------------------------------------------------------------
  localparam logic [2:0] UMP_ADDR_MCR  = 3'h4;
  localparam logic [2:0] UMP_ADDR_FEATURE_CONTROL_REGISTER = 3'h1;
  localparam logic [2:0] UMP_ADDR_EFR  = 3'h2;
  localparam logic [2:0] UMP_ADDR_MSR  = 3'h6;
  localparam logic [2:0] UMP_ADDR_TXD  = 3'h0;
  localparam logic [2:0] UMP_ADDR_STAT = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UMP_MCR_DTR   = 0;
  localparam int UMP_MCR_RTS   = 1;
  localparam int UMP_MCR_OP2   = 3;
  localparam int UMP_MCR_IR    = 6;
  localparam int UMP_FEATURE_CONTROL_REGISTER_IRIN = 2;
  localparam int UMP_FEATURE_CONTROL_REGISTER_DIR  = 3;
  localparam int UMP_EFR_ACTS  = 7;
  localparam int UMP_EFR_ARTS  = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UMP_MCR_RST  = 8'h00;
  localparam logic [7:0] UMP_FEATURE_CONTROL_REGISTER_RST = 8'h00;
  localparam logic [7:0] UMP_EFR_RST  = 8'h00;
  localparam logic [7:0] UMP_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UMP_CLK_NS       = 8;
  localparam int UMP_RST_MIN_NS   = 40;
  // Least time rounds up
  localparam int UMP_RST_MIN_CYC  =
    (UMP_RST_MIN_NS + UMP_CLK_NS - 1) / UMP_CLK_NS;
  localparam int UMP_BIT_CYC      = 16;
  localparam int UMP_FRAME_BITS   = 10;

  // ----------------------------------------------------------------
  // Transmit state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UMP_TX_IDLE = 2'b00,
    UMP_TX_WAIT = 2'b01,
    UMP_TX_SEND = 2'b10
  } ump_tx_state_t;

endpackage : ump_pkg

// ==== core/ump_sync.sv ====
/*
  Two-flop synchroniser for one pin.
  Assumes the pin is asynchronous to clk; reset value is the pin idle level.
*/
`timescale 1ns/10ps
module ump_sync
  import ump_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pin,
  output logic      sync
);

  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = reset ? RST_VAL : pin;
    next_sync = reset ? RST_VAL : meta;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    sync <= next_sync;
  end

endmodule : ump_sync

// ==== core/ump_tx_shift.sv ====
/*
  Simple 8N1 transmit shifter with clear-to-send gating.
  Assumes go is a one-cycle pulse taken only while busy is low.
*/
`timescale 1ns/10ps
module ump_tx_shift
  import ump_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic       cts_block,
  // Result
  output logic            busy,
  output logic            line
);

  ump_tx_state_t state;
  ump_tx_state_t next_state;
  logic [9:0]    shreg;
  logic [9:0]    next_shreg;
  logic [4:0]    cyc;
  logic [4:0]    next_cyc;
  logic [3:0]    bits;
  logic [3:0]    next_bits;

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cyc   = cyc;
    next_bits  = bits;
    case (state)
      UMP_TX_IDLE: begin
        if (go) begin
          next_shreg = {1'b1, data, 1'b0};
          next_state = UMP_TX_WAIT;
        end
      end
      // A character is held back only before its start bit
      UMP_TX_WAIT: begin
        if (!cts_block) begin
          next_state = UMP_TX_SEND;
          next_cyc   = 5'(UMP_BIT_CYC - 1);
          next_bits  = 4'(UMP_FRAME_BITS - 1);
        end
      end
      UMP_TX_SEND: begin
        if (cyc != 5'h0_0) begin
          next_cyc = cyc - 5'h0_1;
        end else if (bits != 4'h0) begin
          next_bits  = bits - 4'h1;
          next_cyc   = 5'(UMP_BIT_CYC - 1);
          next_shreg = {1'b1, shreg[9:1]};
        end else begin
          next_state = UMP_TX_IDLE;
        end
      end
      default: next_state = UMP_TX_IDLE;
    endcase
    if (reset) begin
      next_state = UMP_TX_IDLE;
      next_shreg = 10'h3_FF;
      next_cyc   = 5'h0_0;
      next_bits  = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
    shreg <= next_shreg;
    cyc   <= next_cyc;
    bits  <= next_bits;
  end

  assign busy = (state != UMP_TX_IDLE);
  assign line = (state == UMP_TX_SEND) ? shreg[0] : 1'b1;

endmodule : ump_tx_shift

// ==== dv/ump_pin_sva.sv ====
/*
  Port checker of the channel pin-control block.
  Assumes binding to ump_pin_ctrl and the register map of ump_pkg.
*/
`timescale 1ns/10ps
module ump_pin_sva
  import ump_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic       serial_transmit_out,
  input wire logic       request_to_send_out_n,
  input wire logic       terminal_ready_out_n,
  input wire logic       general_output_two_n,
  input wire logic       irq_request,
  input wire logic       interrupt_out,
  input wire logic       interrupt_oe,
  input wire logic       decoder_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic mcr_wr;
  assign mcr_wr = reg_wr && reg_addr == UMP_ADDR_MCR;

  // Shadow of the mode bits, mirrored from the register writes
  logic dir_on;
  logic ir_on;
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_on <= 1'b0;
      ir_on  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == UMP_ADDR_FEATURE_CONTROL_REGISTER) begin
        dir_on <= reg_wdata[UMP_FEATURE_CONTROL_REGISTER_DIR];
      end
      if (mcr_wr) begin
        ir_on <= reg_wdata[UMP_MCR_IR];
      end
    end
  end

  op2_follow_a: assert property (
    mcr_wr |-> ##2 general_output_two_n == !$past(reg_wdata[UMP_MCR_OP2], 2))
    else $error("general output two off its control bit");
  dtr_follow_a: assert property (
    mcr_wr |-> ##2 terminal_ready_out_n == !$past(reg_wdata[UMP_MCR_DTR], 2))
    else $error("terminal ready off its control bit");
  rts_follow_a: assert property (
    mcr_wr && !dir_on |->
      ##2 request_to_send_out_n == !$past(reg_wdata[UMP_MCR_RTS], 2))
    else $error("request to send off its control bit");
  dir_rts_a: assert property (
    $past(dir_on) && !$past(ir_on) && !serial_transmit_out |->
      !request_to_send_out_n)
    else $error("request to send high while sending");
  oe_pair_a: assert property (
    interrupt_oe == !general_output_two_n)
    else $error("interrupt drive not paired with general output");
  int_gate_a: assert property (
    interrupt_out == ($past(irq_request) && interrupt_oe))
    else $error("interrupt level not gated by drive");
  ir_tx_idle_a: assert property (
    mcr_wr |-> ##2 serial_transmit_out == !$past(reg_wdata[UMP_MCR_IR], 2))
    else $error("transmit idle level wrong for mode");
  msr_low_a: assert property (
    reg_rd && reg_addr == UMP_ADDR_MSR |=> reg_rdata[3:0] == 4'h0)
    else $error("status low nibble not zero");
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> serial_transmit_out && decoder_in && general_output_two_n &&
      !interrupt_oe && terminal_ready_out_n && request_to_send_out_n)
    else $error("outputs not at idle during reset");

  cover property (mcr_wr && reg_wdata[UMP_MCR_OP2]);
  cover property (reg_rd && reg_addr == UMP_ADDR_MSR);
  cover property ($fell(serial_transmit_out) && !reg_wr);
  cover property (dir_on && !request_to_send_out_n);
endmodule : ump_pin_sva

bind ump_pin_ctrl ump_pin_sva ump_pin_sva_i (
  .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .serial_transmit_out, .request_to_send_out_n, .terminal_ready_out_n,
  .general_output_two_n, .irq_request, .interrupt_out, .interrupt_oe,
  .decoder_in
);

// ==== dv/ump_far_model.sv ====
/*
  Far-end transceiver: receive line, modem status pins, frame sampler.
  Assumes 16 clocks per bit and bench control from the clk domain.
*/
`timescale 1ns/10ps
module ump_far_model (
  // Clock
  input  wire logic       clk,
  // Bench control
  input  wire logic       ir_mode,
  input  wire logic       mark,
  input  wire logic       cts_stall,
  input  wire logic [2:0] stat_n,
  // Pins
  input  wire logic       tx_line,
  output logic            serial_receive_in,
  output logic            clear_to_send_in_n,
  output logic            set_ready_in_n,
  output logic            carrier_detect_in_n,
  output logic            ring_indicator_in_n
);
  // Wire line idles high, infrared line idles low
  assign serial_receive_in = ir_mode ? mark : !mark;
  assign clear_to_send_in_n = cts_stall;
  assign {carrier_detect_in_n, ring_indicator_in_n, set_ready_in_n} = stat_n;

  // Mid-bit sampling; bounded wait so a dead line cannot hang the run
  task automatic get_frame(output logic [9:0] f);
    int i;
    i = 0;
    while (tx_line !== 1'b0 && i < 600) begin
      @(posedge clk);
      i++;
    end
    repeat (8) @(posedge clk);
    for (i = 0; i < 10; i++) begin
      f[i] = tx_line;
      repeat (16) @(posedge clk);
    end
  endtask : get_frame
endmodule : ump_far_model

// ==== dv/testbench.sv ====
/*
  Self-checking bench of the channel pin-control block.
  Assumes the checker bind and the far-end model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import ump_pkg::*;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       irq_request = 1'b0;
  logic       ir_mode = 1'b0;
  logic       mark = 1'b0;
  logic       cts_stall = 1'b0;
  logic [2:0] stat_n = 3'h7;
  logic [7:0] reg_rdata, lf, m, d;
  logic [9:0] f;
  logic [4:0] pv;
  logic serial_receive_in, serial_transmit_out, request_to_send_out_n;
  logic clear_to_send_in_n, terminal_ready_out_n, set_ready_in_n;
  logic carrier_detect_in_n, ring_indicator_in_n, general_output_two_n;
  logic interrupt_out, interrupt_oe, decoder_in;
  int   n_mismatch = 0;
  int   check_count = 0;
  int   cyc = 0;

  ump_pin_ctrl ump_pin_ctrl_i (.clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .serial_receive_in, .serial_transmit_out,
    .request_to_send_out_n, .clear_to_send_in_n, .terminal_ready_out_n,
    .set_ready_in_n, .carrier_detect_in_n, .ring_indicator_in_n,
    .general_output_two_n, .irq_request, .interrupt_out, .interrupt_oe,
    .decoder_in);
  ump_far_model ump_far_model_i (.clk, .ir_mode, .mark, .cts_stall,
    .stat_n, .tx_line(serial_transmit_out), .serial_receive_in,
    .clear_to_send_in_n, .set_ready_in_n, .carrier_detect_in_n,
    .ring_indicator_in_n);

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  function automatic logic [7:0] exp_msr(input logic [3:0] s);
    return {~s, 4'h0};
  endfunction : exp_msr
  // Decoder input: infrared idles low, standard line idles high
  function automatic logic exp_dec(input logic ir, mk, inv);
    return ir ? mk ^ inv : !mk;
  endfunction : exp_dec

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    lf = 8'h1c;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(UMP_ADDR_MCR, d);
    `CHK("mcr rst", 8'h00, d)
    pv = {serial_transmit_out, general_output_two_n, request_to_send_out_n,
          interrupt_oe, terminal_ready_out_n};
    `CHK("pins rst", 5'b11101, pv)
    for (int i = 0; i < 16; i++) begin
      lf = nxt(lf);
      m = (lf & 8'h43) | {4'h0, i[0], 3'h0};
      irq_request <= lf[7];
      mark <= lf[2];
      ir_mode <= m[6];
      stat_n <= lf[6:4];
      cts_stall <= lf[3];
      wr(UMP_ADDR_FEATURE_CONTROL_REGISTER, {5'h00, lf[5], 2'h0});
      // Output two moves only together with the interrupt gate
      wr(UMP_ADDR_MCR, m);
      repeat (2) @(posedge clk);
      #1 pv = {general_output_two_n, interrupt_oe, interrupt_out,
               terminal_ready_out_n, request_to_send_out_n};
      `CHK("op2", {!m[3], m[3], m[3] & lf[7]}, pv[4:2])
      `CHK("dtr rts", {!m[0], !m[1]}, pv[1:0])
      `CHK("tx idle", !m[6], serial_transmit_out)
      `CHK("decoder", exp_dec(m[6], lf[2], lf[5]), decoder_in)
      rd(UMP_ADDR_MSR, d);
      `CHK("msr", exp_msr(lf[6:3]), d)
    end
    ir_mode <= 1'b0;
    wr(UMP_ADDR_MCR, 8'h02);
    for (int e = 0; e < 2; e++) begin
      lf = nxt(lf);
      wr(UMP_ADDR_EFR, {e[0], e[0], 6'h00});
      wr(UMP_ADDR_FEATURE_CONTROL_REGISTER, {4'h0, e[0], 3'h0});
      cts_stall <= 1'b1;
      wr(UMP_ADDR_TXD, lf);
      if (e == 1) begin
        repeat (40) @(posedge clk);
        rd(UMP_ADDR_STAT, d);
        pv = {2'b00, d[0], serial_transmit_out, request_to_send_out_n};
        `CHK("held", 3'b110, pv[2:0])
        @(posedge clk);
        cts_stall <= 1'b0;
      end
      stat_n <= lf[2:0];
      ump_far_model_i.get_frame(f);
      `CHK("frame", {1'b1, lf, 1'b0}, f)
      repeat (20) @(posedge clk);
      #1 `CHK("rts end", e[0], request_to_send_out_n)
    end
    wr(UMP_ADDR_TXD, 8'h00);
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    mark <= ~mark;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1 `CHK("in reset", 2'b11, {serial_transmit_out, decoder_in})
    end
    reset <= 1'b0;
    rd(UMP_ADDR_EFR, d);
    `CHK("efr rst", 8'h00, d)
    results();
  end
endmodule : testbench
